// ==== src/trs_pkg.sv ====
// Contract
// - tx power-up follows rise by analog-on delay
// - zero channel delay switches at setup done
// - tx interface held for hold delay
// - tx hold delay forced to zero
// - tx channel off after fall-to-off delay
// - equal delays: interface off before analog
// - zeros sent after latency drains
// - report 8 us or 758 us setup
// - rx power, interface, amplifier sequenced
// - delays stored without clamping
// - rx power-up follows rise by analog-on delay
// - rx interface masked after analog down
package trs_pkg;
  // widths
  localparam int DLY_W = 20;
  localparam int ADDR_W = 8;
  // clock and analog setup times
  localparam int CLK_PERIOD_NS = 40;
  localparam int SETUP_PLAIN_NS = 8000;
  localparam int SETUP_RETUNE_NS = 758000;
  localparam int LO_TUNE_NS = 750000;
  localparam logic [DLY_W-1:0] SETUP_PLAIN_CYC =
    DLY_W'((SETUP_PLAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SETUP_RETUNE_CYC = (SETUP_RETUNE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TX_ANA_ON = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TX_CH_ON = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TX_HOLD = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_TX_FALL_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TX_LATENCY = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RX_ANA_ON = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_RX_CH_ON = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_RX_HOLD = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_SETUP = 8'h28;
  // control fields
  localparam int CTRL_RETUNE_BIT = 0;
  localparam int CTRL_LNA_OWN_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [DLY_W-1:0] DLY_RST = 20'h00000;
  // per-direction phase
  typedef enum logic [1:0] {
    TRS_IDLE = 2'b00,
    TRS_RISE = 2'b01,
    TRS_FALL = 2'b10
  } trs_phase_t;
endpackage

// ==== src/trs_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for an enable pin
module trs_sync
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // pin and synced level
  input  wire logic d_i,
  output logic      q_o
);
  logic meta;  // first stage, read only by q_o

  // plain double flop; pin is asynchronous to clk_i
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // trs_sync
`default_nettype wire

// ==== src/trs_elapsed.sv ====
`timescale 1ns/1ps
`default_nettype none
// cycles since the last restart, saturating
module trs_elapsed
  import trs_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  // control and count
  input  wire logic             restart_i,
  output logic      [DLY_W-1:0] count_o
);
  // restart cycle counts as zero, so the next cycle reads one
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      count_o <= DLY_RST;
    else if (restart_i)
      count_o <= DLY_W'(1);
    else if (count_o != {DLY_W{1'b1}})
      count_o <= count_o + DLY_W'(1);  // saturate, never wraps
  end
endmodule // trs_elapsed
`default_nettype wire

// ==== src/trs_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// tx/rx enable timing sequencer with apb register slave
module trs_top
  import trs_pkg::*;
#(
  // long setup count, shortened in simulation
  parameter int SETUP_RETUNE_CYCLES = SETUP_RETUNE_CYC
)
(
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rstn_i,
  // apb slave
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [trs_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  // enable pins from the baseband processor
  input  wire logic                      tx_enable_i,
  input  wire logic                      rx_enable_i,
  // transmit controls
  output logic                           tx_ana_pwr_o,
  output logic                           tx_ch_on_o,
  output logic                           tx_if_en_o,
  output logic                           tx_zero_fill_o,
  // receive controls
  output logic                           rx_ana_pwr_o,
  output logic                           rx_lna_on_o,
  output logic                           rx_if_en_o
);
  import trs_pkg::*;

  // delay comparison used for every programmed delay
  function automatic logic reached(input logic [DLY_W-1:0] el, input logic [DLY_W:0] dly);
    reached = {1'b0, el} >= dly;
  endfunction
  // widening sum of two delays
  function automatic logic [DLY_W:0] dsum(input logic [DLY_W-1:0] a, input logic [DLY_W-1:0] b);
    dsum = {1'b0, a} + {1'b0, b};
  endfunction
  // software registers
  logic [1:0]       ctrl;         // retune select, amplifier ownership
  logic [DLY_W-1:0] tx_ana_on;    // rise_to_analog_power_delay, tx
  logic [DLY_W-1:0] tx_ch_on;     // rise_to_channel_on_delay, tx
  logic [DLY_W-1:0] tx_hold;      // interface_hold_delay, tx (stored only)
  logic [DLY_W-1:0] tx_fall_off;  // fall_to_channel_off_delay, tx
  logic [DLY_W-1:0] tx_latency;   // transmit_path_latency
  logic [DLY_W-1:0] rx_ana_on;    // rise_to_analog_power_delay, rx
  logic [DLY_W-1:0] rx_ch_on;     // rise_to_channel_on_delay, rx
  logic [DLY_W-1:0] rx_hold;      // interface_hold_delay, rx
  // synced enables and edges
  logic             tx_lvl;       // synced tx enable
  logic             rx_lvl;       // synced rx enable
  logic             tx_lvl_d;     // previous tx level
  logic             rx_lvl_d;     // previous rx level
  logic             tx_edge;      // either tx edge
  logic             rx_edge;      // either rx edge
  logic             tx_rise;
  logic             rx_rise;
  // elapsed counters and effective elapsed time
  logic [DLY_W-1:0] tx_cnt;
  logic [DLY_W-1:0] rx_cnt;
  logic [DLY_W-1:0] tx_el;        // zero in the edge cycle
  logic [DLY_W-1:0] rx_el;
  // sequence state
  trs_phase_t       tx_phase;
  trs_phase_t       rx_phase;
  trs_phase_t       next_tx_phase;
  trs_phase_t       next_rx_phase;
  logic             tx_ready;     // tx analog setup complete
  logic             rx_ready;     // rx analog setup complete
  logic [DLY_W-1:0] setup_cyc;    // analog_setup_time in clocks
  logic             tx_hold_eff;  // forced-zero hold
  // apb decode
  logic             wr_acc;
  logic             setup_ph;
  logic             mapped;
  logic [31:0]      rd_mux;
  // enable pin synchronisers
  trs_sync u_tx_sync
  (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (tx_enable_i),
    .q_o    (tx_lvl)
  );

  trs_sync u_rx_sync
  (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (rx_enable_i),
    .q_o    (rx_lvl)
  );

  // previous levels for edge detection
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_lvl_d <= 1'b0;
      rx_lvl_d <= 1'b0;
    end
    else
    begin
      tx_lvl_d <= tx_lvl;
      rx_lvl_d <= rx_lvl;
    end
  end

  assign tx_edge = tx_lvl ^ tx_lvl_d;
  assign rx_edge = rx_lvl ^ rx_lvl_d;
  assign tx_rise = tx_lvl & ~tx_lvl_d;
  assign rx_rise = rx_lvl & ~rx_lvl_d;
  // elapsed timers, restarted by any edge
  trs_elapsed u_tx_el
  (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .restart_i (tx_edge),
    .count_o   (tx_cnt)
  );

  trs_elapsed u_rx_el
  (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .restart_i (rx_edge),
    .count_o   (rx_cnt)
  );

  // zero delay must act in the edge cycle itself
  assign tx_el = tx_edge ? DLY_RST : tx_cnt;
  assign rx_el = rx_edge ? DLY_RST : rx_cnt;
  // reported setup time follows the retune selection
  assign setup_cyc = ctrl[CTRL_RETUNE_BIT] ? DLY_W'(SETUP_RETUNE_CYCLES)
                                           : SETUP_PLAIN_CYC;
  // tx hold is not honoured yet: interface drops with the enable
  assign tx_hold_eff = 1'b0;
  // phase: the enable level decides; an edge abandons the old sequence
  always_comb
  begin
    next_tx_phase = tx_phase;
    next_rx_phase = rx_phase;
    if (tx_edge)
      next_tx_phase = tx_lvl ? TRS_RISE : TRS_FALL;
    else if (tx_phase == TRS_FALL && !tx_ana_pwr_o && !tx_if_en_o)
      next_tx_phase = TRS_IDLE;
    if (rx_edge)
      next_rx_phase = rx_lvl ? TRS_RISE : TRS_FALL;
    else if (rx_phase == TRS_FALL && !rx_ana_pwr_o && !rx_if_en_o)
      next_rx_phase = TRS_IDLE;
  end

  // phase registers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_phase <= TRS_IDLE;
      rx_phase <= TRS_IDLE;
    end
    else
    begin
      tx_phase <= next_tx_phase;
      rx_phase <= next_rx_phase;
    end
  end

  // transmit sequence
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_ana_pwr_o   <= 1'b0;
      tx_ready       <= 1'b0;
      tx_ch_on_o     <= 1'b0;
      tx_if_en_o     <= 1'b0;
      tx_zero_fill_o <= 1'b0;
    end
    else if (next_tx_phase == TRS_RISE)
    begin
      // interface runs with the enable so guard symbols pass
      tx_if_en_o     <= 1'b1;
      tx_zero_fill_o <= 1'b0;
      tx_ana_pwr_o   <= reached(tx_el, {1'b0, tx_ana_on});
      tx_ready       <= reached(tx_el, dsum(tx_ana_on, setup_cyc));
      // zero channel delay: switch as soon as setup is done
      tx_ch_on_o     <= reached(tx_el, dsum(tx_ana_on, setup_cyc))
                        && reached(tx_el, {1'b0, tx_ch_on});
    end
    else if (next_tx_phase == TRS_FALL)
    begin
      // interface off once the (forced) hold has elapsed
      if (tx_hold_eff ? reached(tx_el, {1'b0, tx_hold}) : 1'b1)
        tx_if_en_o <= 1'b0;
      // analog waits for a closed interface, so equal delays still order
      if (!tx_if_en_o && reached(tx_el, {1'b0, tx_fall_off}))
      begin
        tx_ana_pwr_o   <= 1'b0;
        tx_ch_on_o     <= 1'b0;
        tx_ready       <= 1'b0;
        tx_zero_fill_o <= 1'b0;
      end
      else if (tx_ana_pwr_o && reached(tx_el, dsum(DLY_RST, tx_latency)))
        tx_zero_fill_o <= 1'b1;
    end
    else
    begin
      tx_ana_pwr_o   <= 1'b0;
      tx_ready       <= 1'b0;
      tx_ch_on_o     <= 1'b0;
      tx_if_en_o     <= 1'b0;
      tx_zero_fill_o <= 1'b0;
    end
  end

  // receive sequence; amplifier only when this block owns it
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rx_ana_pwr_o <= 1'b0;
      rx_ready     <= 1'b0;
      rx_lna_on_o  <= 1'b0;
      rx_if_en_o   <= 1'b0;
    end
    else if (next_rx_phase == TRS_RISE)
    begin
      rx_ana_pwr_o <= reached(rx_el, {1'b0, rx_ana_on});
      rx_ready     <= reached(rx_el, dsum(rx_ana_on, setup_cyc));
      rx_lna_on_o  <= ctrl[CTRL_LNA_OWN_BIT]
                      && reached(rx_el, dsum(rx_ana_on, setup_cyc))
                      && reached(rx_el, {1'b0, rx_ch_on});
      rx_if_en_o   <= reached(rx_el, dsum(rx_ana_on, setup_cyc));
    end
    else if (next_rx_phase == TRS_FALL)
    begin
      // fall-to-off is forced to zero: analog and amplifier drop at once
      rx_ana_pwr_o <= 1'b0;
      rx_lna_on_o  <= 1'b0;
      rx_ready     <= 1'b0;
      // mask data only after analog is down and the hold has run
      if (!rx_ana_pwr_o && reached(rx_el, {1'b0, rx_hold}))
        rx_if_en_o <= 1'b0;
    end
    else
    begin
      rx_ana_pwr_o <= 1'b0;
      rx_ready     <= 1'b0;
      rx_lna_on_o  <= 1'b0;
      rx_if_en_o   <= 1'b0;
    end
  end

  // apb phases: no wait state, pready raised in the access cycle
  assign setup_ph = psel_i && !penable_i;
  assign wr_acc   = psel_i && penable_i && pready_o && pwrite_i;
  assign mapped   = (paddr_i[1:0] == 2'b00) && (paddr_i <= OFS_SETUP);
  // read mux, unused bits read zero
  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (paddr_i)
      OFS_CTRL:        rd_mux = {30'h0, ctrl};
      OFS_TX_ANA_ON:   rd_mux = {12'h0, tx_ana_on};
      OFS_TX_CH_ON:    rd_mux = {12'h0, tx_ch_on};
      OFS_TX_HOLD:     rd_mux = {12'h0, tx_hold};
      OFS_TX_FALL_OFF: rd_mux = {12'h0, tx_fall_off};
      OFS_TX_LATENCY:  rd_mux = {12'h0, tx_latency};
      OFS_RX_ANA_ON:   rd_mux = {12'h0, rx_ana_on};
      OFS_RX_CH_ON:    rd_mux = {12'h0, rx_ch_on};
      OFS_RX_HOLD:     rd_mux = {12'h0, rx_hold};
      OFS_STATUS:      rd_mux = {19'h0, rx_phase, tx_phase, rx_ready, tx_ready,
                                 rx_if_en_o, rx_lna_on_o, rx_ana_pwr_o, tx_zero_fill_o,
                                 tx_if_en_o, tx_ch_on_o, tx_ana_pwr_o};
      OFS_SETUP:       rd_mux = {12'h0, setup_cyc};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // bus answer registers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end
    else
    begin
      pready_o  <= setup_ph;
      pslverr_o <= setup_ph && !mapped;
      if (setup_ph)
        prdata_o <= (mapped && !pwrite_i) ? rd_mux : 32'h00000000;
    end
  end

  // register writes: values taken as given, no bounds check
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl        <= CTRL_RST;
      tx_ana_on   <= DLY_RST;
      tx_ch_on    <= DLY_RST;
      tx_hold     <= DLY_RST;
      tx_fall_off <= DLY_RST;
      tx_latency  <= DLY_RST;
      rx_ana_on   <= DLY_RST;
      rx_ch_on    <= DLY_RST;
      rx_hold     <= DLY_RST;
    end
    else if (wr_acc)
    begin
      unique case (paddr_i)
        OFS_CTRL:        ctrl        <= pwdata_i[1:0];
        OFS_TX_ANA_ON:   tx_ana_on   <= pwdata_i[DLY_W-1:0];
        OFS_TX_CH_ON:    tx_ch_on    <= pwdata_i[DLY_W-1:0];
        OFS_TX_HOLD:     tx_hold     <= pwdata_i[DLY_W-1:0];
        OFS_TX_FALL_OFF: tx_fall_off <= pwdata_i[DLY_W-1:0];
        OFS_TX_LATENCY:  tx_latency  <= pwdata_i[DLY_W-1:0];
        OFS_RX_ANA_ON:   rx_ana_on   <= pwdata_i[DLY_W-1:0];
        OFS_RX_CH_ON:    rx_ch_on    <= pwdata_i[DLY_W-1:0];
        OFS_RX_HOLD:     rx_hold     <= pwdata_i[DLY_W-1:0];
        default:         ctrl        <= ctrl;  // read-only or unmapped
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_tx_fall;
    tx_edge && !tx_lvl;
  endsequence
  a_tx_pwr_zero: assert property (tx_rise && tx_ana_on == DLY_RST |=> tx_ana_pwr_o)
    else $error("tx analog not powered at rise with zero delay");
  a_tx_ch_ready: assert property ($rose(tx_ch_on_o) |-> tx_ready)
    else $error("tx channel on before setup done");
  a_tx_hold_zero: assert property (s_tx_fall |=> !tx_if_en_o)
    else $error("tx interface held past fall");
  a_tx_if_first: assert property ($fell(tx_ana_pwr_o) && tx_phase == TRS_FALL
                                  |-> $past(tx_if_en_o) == 1'b0)
    else $error("tx analog dropped before interface");
  a_tx_off_delay: assert property (s_tx_fall ##0 (tx_fall_off <= DLY_W'(1))
                                   ##1 !tx_edge |=> !tx_ana_pwr_o)
    else $error("tx analog not off after fall delay");
  a_tx_zero_pwr: assert property (tx_zero_fill_o |-> tx_ana_pwr_o && !tx_if_en_o)
    else $error("zero fill without analog");
  a_rx_pwr_zero: assert property (rx_rise && rx_ana_on == DLY_RST |=> rx_ana_pwr_o)
    else $error("rx analog not powered at rise with zero delay");
  a_rx_if_after: assert property ($fell(rx_if_en_o) |-> !rx_ana_pwr_o)
    else $error("rx interface masked before analog down");
  a_lna_owned: assert property (rx_lna_on_o |-> ctrl[CTRL_LNA_OWN_BIT] && rx_ready)
    else $error("amplifier on without ownership or setup");
  a_tx_restart: assert property (tx_edge |=> tx_cnt == DLY_W'(1))
    else $error("tx timer not restarted by edge");
  a_setup_sel: assert property ($rose(tx_ready) |-> tx_el >= setup_cyc)
    else $error("tx setup shorter than reported");
endmodule // trs_top
`default_nettype wire

// ==== sim/trs_bb_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// baseband processor side: enable pins and the external antenna switch
module trs_bb_model
(
  // clock
  input  wire logic clk_i,
  // device state seen by the processor
  input  wire logic tx_ana_pwr_i,
  // enable pins
  output var  logic tx_enable_o,
  output var  logic rx_enable_o,
  // antenna switch owned by the processor
  output var  logic antenna_tx_o
);
  // pins idle low from time zero
  initial
  begin
    tx_enable_o  = 1'b0;
    rx_enable_o  = 1'b0;
    antenna_tx_o = 1'b0;
  end
  // bench calls these right after a rising edge, so pins move off the sampling point
  task automatic set_tx(input logic v);
    tx_enable_o <= v;
  endtask
  task automatic set_rx(input logic v);
    rx_enable_o <= v;
  endtask
  // antenna on only after analog power, off with the enable so before power-down
  always @(posedge clk_i)
    antenna_tx_o <= tx_ana_pwr_i & tx_enable_o;
endmodule // trs_bb_model
`default_nettype wire

// ==== sim/tb_tx_rx_enable_timing_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
// scenario bench for the enable timing sequencer
module tb_tx_rx_enable_timing_sequencer;
  import trs_pkg::*;
  localparam int RET = 20; // short retune setup keeps the run brief
  logic              clk_i, rstn_i, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata_o;
  logic              pready_o, pslverr_o, tx_en, rx_en;
  logic [6:0]        outs, prev; // same bit order as the status word
  logic              tx_pwr, tx_ch, tx_if, tx_zf, rx_pwr, rx_lna, rx_if, ant;
  int                cyc, errors, n_tests, t_pin, lat, stp;
  int                t_up[7], t_dn[7], n_up[7]; // last edge times and rise counts

  trs_top #(.SETUP_RETUNE_CYCLES(RET)) uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_enable_i(tx_en), .rx_enable_i(rx_en),
    .tx_ana_pwr_o(tx_pwr), .tx_ch_on_o(tx_ch), .tx_if_en_o(tx_if),
    .tx_zero_fill_o(tx_zf), .rx_ana_pwr_o(rx_pwr), .rx_lna_on_o(rx_lna),
    .rx_if_en_o(rx_if));
  assign outs = {rx_if, rx_lna, rx_pwr, tx_zf, tx_if, tx_ch, tx_pwr};
  trs_bb_model bb (.clk_i(clk_i), .tx_ana_pwr_i(tx_pwr), .tx_enable_o(tx_en),
    .rx_enable_o(rx_en), .antenna_tx_o(ant));

  // 25 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // timestamps taken at the falling edge, clear of the launching edge
  always @(negedge clk_i)
  begin
    cyc = cyc + 1;
    for (int i = 0; i < 7; i++)
      if (outs[i] !== prev[i])
      begin
        if (outs[i] === 1'b1)
        begin
          t_up[i] = cyc;
          n_up[i]++;
        end
        else
          t_dn[i] = cyc;
      end
    prev = outs;
  end
  // comparisons
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cyc(input int got, input int exp);
    n_tests++;
    if (got != exp)
    begin
      errors++;
      $display("[ERR] %0t cycles %0d expected %0d", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge clk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rd = prdata_o;
    er = pslverr_o;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk_val(r, x);
    chk_val({31'h0, e}, {31'h0, ex});
  endtask
  // bounded wait for one output level
  task automatic wait_lvl(input int i, input logic v);
    int k;
    k = 0;
    while (outs[i] !== v && k < 2000)
    begin
      @(posedge clk_i);
      k++;
    end
    chk_val({31'h0, outs[i]}, {31'h0, v});
  endtask
  task automatic clr;
    for (int i = 0; i < 7; i++) n_up[i] = 0;
  endtask
  // reset values, read-only setup word, unclamped delay, refused addresses
  task automatic t_regs;
    for (int a = 0; a <= 32'h24; a += 4) rchk(8'(a), 32'h0, 1'b0);
    rchk(OFS_SETUP, {12'h0, SETUP_PLAIN_CYC}, 1'b0);
    wr(OFS_RX_CH_ON, 32'h000fffff);
    rchk(OFS_RX_CH_ON, 32'h000fffff, 1'b0);
    wr(OFS_RX_CH_ON, 32'h0);
    wr(OFS_SETUP, 32'h5);
    rchk(OFS_SETUP, {12'h0, SETUP_PLAIN_CYC}, 1'b0);
    rchk(8'h2c, 32'h0, 1'b1);
    rchk(8'h05, 32'h0, 1'b1);
  endtask
  // one transmit burst, timings judged against the programmed delays
  task automatic t_tx(input int ana, input int ch, input int fo, input int hold,
                      input int lt, input int z);
    wr(OFS_TX_ANA_ON, ana);
    wr(OFS_TX_CH_ON, ch);
    wr(OFS_TX_FALL_OFF, fo);
    wr(OFS_TX_HOLD, hold);
    wr(OFS_TX_LATENCY, lt);
    clr;
    @(posedge clk_i);
    bb.set_tx(1'b1);
    t_pin = cyc;
    wait_lvl(1, 1'b1);
    chk_val({31'h0, ant}, 32'h1);
    chk_cyc(t_up[2] - t_pin, lat);
    chk_cyc(t_up[0] - t_up[2], ana);
    chk_cyc(t_up[1] - t_up[2], (ana + stp > ch) ? ana + stp : ch);
    @(posedge clk_i);
    bb.set_tx(1'b0);
    t_pin = cyc;
    wait_lvl(0, 1'b0);
    chk_cyc(t_dn[2] - t_pin, lat);
    chk_cyc(t_dn[0] - t_dn[2], (fo > 1) ? fo : 1);
    chk_cyc(t_dn[1], t_dn[0]);
    chk_cyc(n_up[3], z);
    if (z != 0) chk_cyc(t_dn[3], t_dn[0]);
  endtask
  // enable dropped and raised again mid power-up: only the new sequence counts
  task automatic t_restart;
    wr(OFS_TX_ANA_ON, 32'h0);
    wr(OFS_TX_CH_ON, 32'h0);
    wr(OFS_TX_FALL_OFF, 32'h0);
    clr;
    @(posedge clk_i);
    bb.set_tx(1'b1);
    repeat (10) @(posedge clk_i);
    bb.set_tx(1'b0);
    repeat (4) @(posedge clk_i);
    bb.set_tx(1'b1);
    wait_lvl(1, 1'b1);
    chk_cyc(t_up[1] - t_up[2], stp);
    chk_cyc(n_up[1], 1);
    @(posedge clk_i);
    bb.set_tx(1'b0);
    wait_lvl(0, 1'b0);
  endtask
  // one receive burst, with or without amplifier ownership
  task automatic t_rx(input logic own, input int ana, input int hold);
    wr(OFS_CTRL, {30'h0, own, 1'b1}); // retune kept, so stp stays the short setup
    wr(OFS_RX_ANA_ON, ana);
    wr(OFS_RX_HOLD, hold);
    clr;
    @(posedge clk_i);
    bb.set_rx(1'b1);
    t_pin = cyc;
    wait_lvl(6, 1'b1);
    chk_cyc(t_up[4] - t_pin, lat + ana);
    chk_cyc(t_up[6] - t_up[4], stp);
    chk_cyc(n_up[5], int'(own));
    if (own) chk_cyc(t_up[5], t_up[6]);
    @(posedge clk_i);
    bb.set_rx(1'b0);
    t_pin = cyc;
    wait_lvl(6, 1'b0);
    chk_cyc(t_dn[4] - t_pin, lat);
    chk_cyc(t_dn[6] - t_dn[4], (hold > 1) ? hold : 1);
  endtask
  // verdict and end of run
  task automatic close_out;
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    rstn_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    cyc = 0; errors = 0; n_tests = 0; stp = SETUP_PLAIN_CYC;
    lat = 4; // two sync flops and the output flop, seen at the next falling stamp
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_regs;
    t_tx(0, 0, 0, 0, 50, 0);
    t_tx(5, 300, 8, 5, 50, 0);
    t_tx(0, 0, 12, 0, 3, 1);
    wr(OFS_CTRL, 32'h1);
    rchk(OFS_SETUP, RET, 1'b0);
    stp = RET;
    t_tx(30, 0, 1, 0, 50, 0);
    t_restart;
    t_rx(1'b1, 4, 6);
    t_rx(1'b0, 0, 0);
    close_out;
  end
  // hang guard, more than ten times the expected run length
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    close_out;
  end
endmodule // tb_tx_rx_enable_timing_sequencer
`default_nettype wire
